// file: rtl/lvt_video_timing_regs.sv
// timing registers and test-pattern raster generator for the panel link
// assumes register port on mclk, pixel clock pclk from the link side, rstn sync low
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module lvt_video_timing_regs import lvt_pkg::*; (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic [REG_AW-1:0] regAddr,
   input  wire logic [REG_DW-1:0] regWdata,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [REG_DW-1:0] regRdata,
   input  wire logic              pclk,
   output logic                   lineSync,
   output logic                   frameSync,
   output logic                   dataEnable,
   output logic      [PIX_W-1:0]  pixelData,
   output logic                   chanAEnable,
   output logic                   chanBEnable
);
   localparam int CFG_W = N_REG * REG_DW;

   // ---------------- register port domain
   logic [REG_DW-1:0] regs       [N_REG];
   logic [REG_DW-1:0] next_regs  [N_REG];
   logic [REG_DW-1:0] next_regRdata;
   logic              dirty;
   logic              next_dirty;
   logic              reqTog;
   logic              next_reqTog;
   logic [CFG_W-1:0]  shadow;
   logic [CFG_W-1:0]  next_shadow;
   logic              ackSync;
   logic [1:0]        statSync;
   logic              busy;

   // ---------------- pixel domain
   logic              prstnSync;
   logic              reqSync;
   logic              reqSeen;
   logic [CFG_W-1:0]  pcfg;
   logic              pgenOn;
   logic              singleChan;
   logic [SYNC_W-1:0] inLs;
   logic [SYNC_W-1:0] inFs;
   logic [SIZE_W-1:0] inLa;
   logic [SIZE_W-1:0] inFa;
   logic [7:0]        inLb;
   logic [7:0]        inLf;
   logic [7:0]        inFb;
   logic [7:0]        inFf;

   assign busy = (reqTog != ackSync);

   always_comb begin
      next_regs     = regs;
      next_dirty    = dirty;
      next_reqTog   = reqTog;
      next_shadow   = shadow;
      next_regRdata = '0;
      // hand a snapshot to the pixel side only when the previous one was taken
      if (!busy && dirty) begin
         for (int i = 0; i < N_REG; i++) next_shadow[i*REG_DW +: REG_DW] = regs[i];
         next_reqTog = ~reqTog;
         next_dirty  = 1'b0;
      end
      // a write in the same cycle keeps the dirty flag set
      if (regWr) begin
         for (int i = 0; i < N_REG; i++) begin
            if (regAddr == REG_OFS[i]) begin
               next_regs[i] = regWdata & REG_MASK[i];
               next_dirty   = 1'b1;
            end
         end
      end
      if (regRd) begin
         for (int i = 0; i < N_REG; i++) begin
            if (regAddr == REG_OFS[i]) next_regRdata = regs[i];
         end
         if (regAddr == OFS_STATUS) begin
            next_regRdata[STAT_BUSY_BIT]  = busy | dirty;
            next_regRdata[STAT_RUN_BIT]   = statSync[0];
            next_regRdata[STAT_FSYNC_BIT] = statSync[1];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         for (int i = 0; i < N_REG; i++) regs[i] <= REG_RESET;
         regRdata <= '0;
         dirty    <= 1'b0;
         reqTog   <= 1'b0;
         shadow   <= '0;
      end else begin
         regs     <= next_regs;
         regRdata <= next_regRdata;
         dirty    <= next_dirty;
         reqTog   <= next_reqTog;
         shadow   <= next_shadow;
      end
   end

   lvt_sync2 #(.W(1)) uAckSync  (.clk(mclk), .din(reqSeen), .dout(ackSync));
   lvt_sync2 #(.W(2)) uStatSync (.clk(mclk), .din({frameSync, chanAEnable}), .dout(statSync));
   lvt_sync2 #(.W(1)) uRstSync  (.clk(pclk), .din(rstn), .dout(prstnSync));
   lvt_sync2 #(.W(1)) uReqSync  (.clk(pclk), .din(reqTog), .dout(reqSync));

   // shadow is held stable until reqSeen is seen back on mclk
   always_ff @(posedge pclk) begin
      if (!prstnSync) begin
         reqSeen <= 1'b0;
         pcfg    <= '0;
      end else if (reqSync != reqSeen) begin
         reqSeen <= reqSync;
         pcfg    <= shadow;
      end
   end

   assign pgenOn     = pcfg[IDX_PGEN*REG_DW + PGEN_EN_BIT];
   assign singleChan = pcfg[IDX_CHAN_MODE*REG_DW + CHAN_MODE_BIT];
   assign inLs = {pcfg[IDX_LSYNC_HI*REG_DW +: 2], pcfg[IDX_LSYNC_LO*REG_DW +: REG_DW]};
   assign inFs = {pcfg[IDX_FSYNC_HI*REG_DW +: 2], pcfg[IDX_FSYNC_LO*REG_DW +: REG_DW]};
   assign inLa = {pcfg[IDX_ACT_PIX_HI*REG_DW +: 4], pcfg[IDX_ACT_PIX_LO*REG_DW +: REG_DW]};
   assign inFa = {pcfg[IDX_ACT_LINES_HI*REG_DW +: 4], pcfg[IDX_ACT_LINES_LO*REG_DW +: REG_DW]};
   assign inLb = pcfg[IDX_LINE_BP*REG_DW +: PORCH_W];
   assign inLf = pcfg[IDX_LINE_FP*REG_DW +: PORCH_W];
   assign inFb = pcfg[IDX_FRAME_BP*REG_DW +: PORCH_W];
   assign inFf = pcfg[IDX_FRAME_FP*REG_DW +: PORCH_W];

   // ---------------- raster generator
   logic              run;
   logic              next_run;
   lvt_seg_e          hSeg;
   lvt_seg_e          next_hSeg;
   lvt_seg_e          vSeg;
   lvt_seg_e          next_vSeg;
   logic [SIZE_W-1:0] hCnt;
   logic [SIZE_W-1:0] next_hCnt;
   logic [SIZE_W-1:0] vCnt;
   logic [SIZE_W-1:0] next_vCnt;
   logic [SYNC_W-1:0] wLs, next_wLs, wFs, next_wFs;
   logic [SIZE_W-1:0] wLa, next_wLa, wFa, next_wFa;
   logic [7:0]        wLb, next_wLb, wLf, next_wLf, wFb, next_wFb, wFf, next_wFf;
   logic [3:0]        hNz, vNz, inHNz, inVNz;
   logic [SIZE_W-1:0] hLen, vLen;
   logic              lineEnd, frameEnd, loadCfg;
   logic              next_lineSync, next_frameSync, next_dataEnable, next_chanA, next_chanB;
   logic [PIX_W-1:0]  next_pixelData;

   function automatic logic [SIZE_W-1:0] segLen(input lvt_seg_e s, input logic [SIZE_W-1:0] a, b, c, d);
      case (s)
         SEG_SYNC:   return a;
         SEG_BACK:   return b;
         SEG_ACTIVE: return c;
         default:    return d;
      endcase
   endfunction : segLen

   function automatic logic [3:0] nzOf(input logic [SIZE_W-1:0] a, b, c, d);
      return {d != '0, c != '0, b != '0, a != '0};
   endfunction : nzOf

   always_comb begin
      hNz   = nzOf(SIZE_W'(wLs), SIZE_W'(wLb), wLa, SIZE_W'(wLf));
      vNz   = nzOf(SIZE_W'(wFs), SIZE_W'(wFb), wFa, SIZE_W'(wFf));
      inHNz = nzOf(SIZE_W'(inLs), SIZE_W'(inLb), inLa, SIZE_W'(inLf));
      inVNz = nzOf(SIZE_W'(inFs), SIZE_W'(inFb), inFa, SIZE_W'(inFf));
      hLen  = segLen(hSeg, SIZE_W'(wLs), SIZE_W'(wLb), wLa, SIZE_W'(wLf));
      vLen  = segLen(vSeg, SIZE_W'(wFs), SIZE_W'(wFb), wFa, SIZE_W'(wFf));
      lineEnd   = 1'b0;
      frameEnd  = 1'b0;
      loadCfg   = 1'b0;
      next_run  = run;
      next_hSeg = hSeg;
      next_vSeg = vSeg;
      next_hCnt = hCnt;
      next_vCnt = vCnt;
      if (!pgenOn) begin
         next_run = 1'b0;
      end else if (!run) begin
         loadCfg = 1'b1;
      end else begin
         if ({1'b0, hCnt} + 13'h1 >= {1'b0, hLen}) begin
            next_hCnt = '0;
            next_hSeg = lvt_next_seg(hSeg, hNz);
            lineEnd   = (next_hSeg <= hSeg);
         end else begin
            next_hCnt = hCnt + 12'h1;
         end
         if (lineEnd) begin
            if ({1'b0, vCnt} + 13'h1 >= {1'b0, vLen}) begin
               next_vCnt = '0;
               next_vSeg = lvt_next_seg(vSeg, vNz);
               frameEnd  = (next_vSeg <= vSeg);
            end else begin
               next_vCnt = vCnt + 12'h1;
            end
         end
         loadCfg = frameEnd;
      end
      // new line and frame timing settings only take effect on a frame boundary, so no torn frame; enable and channel mode act at once
      if (loadCfg) begin
         next_run  = (|inHNz) && (|inVNz);
         next_hSeg = lvt_next_seg(SEG_FRONT, inHNz);
         next_vSeg = lvt_next_seg(SEG_FRONT, inVNz);
         next_hCnt = '0;
         next_vCnt = '0;
         next_wLs = inLs; next_wLb = inLb; next_wLa = inLa; next_wLf = inLf;
         next_wFs = inFs; next_wFb = inFb; next_wFa = inFa; next_wFf = inFf;
      end else begin
         next_wLs = wLs; next_wLb = wLb; next_wLa = wLa; next_wLf = wLf;
         next_wFs = wFs; next_wFb = wFb; next_wFa = wFa; next_wFf = wFf;
      end
      next_lineSync   = next_run && (next_hSeg == SEG_SYNC);
      next_frameSync  = next_run && (next_vSeg == SEG_SYNC);
      next_dataEnable = next_run && (next_hSeg == SEG_ACTIVE) && (next_vSeg == SEG_ACTIVE);
      next_pixelData  = next_dataEnable ?
                        {next_hCnt[7:0], next_vCnt[7:0], next_hCnt[7:0] ^ next_vCnt[7:0]} : '0;
      next_chanA      = next_run;
      next_chanB      = next_run && !singleChan;
   end

   always_ff @(posedge pclk) begin
      if (!prstnSync) begin
         run <= 1'b0; hSeg <= SEG_SYNC; vSeg <= SEG_SYNC; hCnt <= '0; vCnt <= '0;
         wLs <= '0; wLb <= '0; wLa <= '0; wLf <= '0;
         wFs <= '0; wFb <= '0; wFa <= '0; wFf <= '0;
         lineSync <= 1'b0; frameSync <= 1'b0; dataEnable <= 1'b0; pixelData <= '0;
         chanAEnable <= 1'b0; chanBEnable <= 1'b0;
      end else begin
         run <= next_run; hSeg <= next_hSeg; vSeg <= next_vSeg; hCnt <= next_hCnt; vCnt <= next_vCnt;
         wLs <= next_wLs; wLb <= next_wLb; wLa <= next_wLa; wLf <= next_wLf;
         wFs <= next_wFs; wFb <= next_wFb; wFa <= next_wFa; wFf <= next_wFf;
         lineSync <= next_lineSync; frameSync <= next_frameSync; dataEnable <= next_dataEnable;
         pixelData <= next_pixelData; chanAEnable <= next_chanA; chanBEnable <= next_chanB;
      end
   end

   // ---------------- checks
   logic [SYNC_W:0] syncRun;
   logic [8:0]      gapCnt;

   always_ff @(posedge pclk) begin
      if (!prstnSync) begin
         syncRun <= '0;
         gapCnt  <= '0;
      end else begin
         syncRun <= lineSync ? syncRun + 11'h1 : '0;
         gapCnt  <= lineSync ? '0 : ((gapCnt == 9'h1FF) ? gapCnt : gapCnt + 9'h1);
      end
   end

   sequence s_sync_end;
      run ##0 $fell(lineSync);
   endsequence

   sequence s_wr_rd(logic [7:0] ofs);
      (regWr && regAddr == ofs) ##1 (regRd && regAddr == ofs);
   endsequence

   a_line_sync_width: assert property (@(posedge pclk) disable iff (!prstnSync)
      s_sync_end |-> syncRun == {1'b0, wLs})
      else $error("line sync width differs from programmed count");

   a_line_back_porch: assert property (@(posedge pclk) disable iff (!prstnSync)
      $rose(dataEnable) && wLs != '0 |-> gapCnt == {1'b0, wLb})
      else $error("line back porch differs from programmed count");

   a_line_front_porch: assert property (@(posedge pclk) disable iff (!prstnSync)
      $past(run) && run && $past(hSeg) == SEG_FRONT && hSeg != SEG_FRONT
      |-> $past(hCnt) == SIZE_W'($past(wLf)) - 12'h1)
      else $error("line front porch differs from programmed count");

   a_frame_sync_lines: assert property (@(posedge pclk) disable iff (!prstnSync)
      $past(run) && run && $past(vSeg) == SEG_SYNC && vSeg != SEG_SYNC
      |-> $past(vCnt) == SIZE_W'($past(wFs)) - 12'h1)
      else $error("frame sync length differs from programmed lines");

   a_frame_back_porch: assert property (@(posedge pclk) disable iff (!prstnSync)
      $past(run) && run && $past(vSeg) == SEG_BACK && vSeg != SEG_BACK
      |-> $past(vCnt) == SIZE_W'($past(wFb)) - 12'h1)
      else $error("frame back porch differs from programmed lines");

   a_frame_front_porch: assert property (@(posedge pclk) disable iff (!prstnSync)
      $past(run) && run && $past(vSeg) == SEG_FRONT && vSeg != SEG_FRONT
      |-> $past(vCnt) == SIZE_W'($past(wFf)) - 12'h1)
      else $error("frame front porch differs from programmed lines");

   a_active_line_count: assert property (@(posedge pclk) disable iff (!prstnSync)
      $past(run) && run && $past(vSeg) == SEG_ACTIVE && vSeg != SEG_ACTIVE
      |-> $past(vCnt) == $past(wFa) - 12'h1)
      else $error("active line count differs from programmed size");

   a_pattern_off: assert property (@(posedge pclk) disable iff (!prstnSync)
      !pgenOn |=> !lineSync && !frameSync && !dataEnable && pixelData == '0 && !chanAEnable)
      else $error("pattern output active while disabled");

   a_chan_b_mode: assert property (@(posedge pclk) disable iff (!prstnSync)
      chanBEnable |-> chanAEnable && !$past(singleChan))
      else $error("channel B driven in single channel mode");

   a_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn)
      s_wr_rd(OFS_LSYNC_HI) |=> regRdata == ($past(regWdata, 2) & 8'h03))
      else $error("reserved bits of line sync upper register not zero");

   a_pgen_readback: assert property (@(posedge mclk) disable iff (!rstn)
      s_wr_rd(OFS_PGEN) |=> regRdata == ($past(regWdata, 2) & REG_MASK[IDX_PGEN]))
      else $error("pattern control read back wrong");

   a_cfg_handoff: assert property (@(posedge mclk) disable iff (!rstn)
      $changed(reqTog) |-> ##[1:20] !busy)
      else $error("settings hand-over to pixel side took too long");

   // one read answer per read strobe, nothing in between
   a_rdata_idle: assert property (@(posedge mclk) disable iff (!rstn)
      !$past(regRd) |-> regRdata == '0)
      else $error("read data not zero outside the answer cycle");

   // snapshot must not move while the pixel side may be copying it
   a_shadow_hold: assert property (@(posedge mclk) disable iff (!rstn)
      busy && $past(busy) |-> $stable(shadow))
      else $error("settings snapshot changed during hand-over");

   sequence s_gen_start;
      pgenOn && !run && (|inHNz) && (|inVNz);
   endsequence

   a_pattern_start: assert property (@(posedge pclk) disable iff (!prstnSync)
      s_gen_start |=> run && chanAEnable && lineSync == (wLs != '0))
      else $error("pattern did not start one pixel clock after enable");

   a_frame_starts_line: assert property (@(posedge pclk) disable iff (!prstnSync)
      $rose(frameSync) && wLs != '0 |-> lineSync)
      else $error("frame sync began outside a line sync");

   a_line_active_width: assert property (@(posedge pclk) disable iff (!prstnSync)
      $past(run) && run && $past(hSeg) == SEG_ACTIVE && hSeg != SEG_ACTIVE
      |-> $past(hCnt) == $past(wLa) - 12'h1)
      else $error("active pixel count differs from programmed size");

   a_blank_pixels: assert property (@(posedge pclk) disable iff (!prstnSync)
      !dataEnable |-> pixelData == '0)
      else $error("pixel data not blank outside active video");

endmodule : lvt_video_timing_regs

// file: rtl/lvt_pkg.sv
// constants, register map and shared helpers of the video timing register block
// assumes one register port clock domain and one pixel clock domain at the link
package lvt_pkg;

   localparam int REG_AW = 8;
   localparam int REG_DW = 8;
   localparam int N_REG  = 14;
   localparam int SYNC_W  = 10;
   localparam int PORCH_W = 8;
   localparam int SIZE_W  = 12;
   localparam int PIX_W   = 24;

   localparam logic [7:0] OFS_CHAN_MODE    = 8'h18;
   localparam logic [7:0] OFS_ACT_PIX_LO   = 8'h20;
   localparam logic [7:0] OFS_ACT_PIX_HI   = 8'h21;
   localparam logic [7:0] OFS_ACT_LINES_LO = 8'h24;
   localparam logic [7:0] OFS_ACT_LINES_HI = 8'h25;
   localparam logic [7:0] OFS_LSYNC_LO     = 8'h2C;
   localparam logic [7:0] OFS_LSYNC_HI     = 8'h2D;
   localparam logic [7:0] OFS_FSYNC_LO     = 8'h30;
   localparam logic [7:0] OFS_FSYNC_HI     = 8'h31;
   localparam logic [7:0] OFS_LINE_BP      = 8'h34;
   localparam logic [7:0] OFS_FRAME_BP     = 8'h36;
   localparam logic [7:0] OFS_LINE_FP      = 8'h38;
   localparam logic [7:0] OFS_FRAME_FP     = 8'h3A;
   localparam logic [7:0] OFS_PGEN         = 8'h3C;
   localparam logic [7:0] OFS_STATUS       = 8'h3D;

   localparam int IDX_CHAN_MODE    = 0;
   localparam int IDX_ACT_PIX_LO   = 1;
   localparam int IDX_ACT_PIX_HI   = 2;
   localparam int IDX_ACT_LINES_LO = 3;
   localparam int IDX_ACT_LINES_HI = 4;
   localparam int IDX_LSYNC_LO     = 5;
   localparam int IDX_LSYNC_HI     = 6;
   localparam int IDX_FSYNC_LO     = 7;
   localparam int IDX_FSYNC_HI     = 8;
   localparam int IDX_LINE_BP      = 9;
   localparam int IDX_FRAME_BP     = 10;
   localparam int IDX_LINE_FP      = 11;
   localparam int IDX_FRAME_FP     = 12;
   localparam int IDX_PGEN         = 13;

   localparam logic [7:0] REG_OFS [0:N_REG-1] = '{OFS_CHAN_MODE, OFS_ACT_PIX_LO, OFS_ACT_PIX_HI,
      OFS_ACT_LINES_LO, OFS_ACT_LINES_HI, OFS_LSYNC_LO, OFS_LSYNC_HI, OFS_FSYNC_LO, OFS_FSYNC_HI,
      OFS_LINE_BP, OFS_FRAME_BP, OFS_LINE_FP, OFS_FRAME_FP, OFS_PGEN};
   localparam logic [7:0] REG_MASK [0:N_REG-1] = '{8'h10, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h03,
      8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h10};
   localparam logic [7:0] REG_RESET = 8'h00;

   localparam int CHAN_MODE_BIT   = 4;
   localparam int PGEN_EN_BIT     = 4;
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_RUN_BIT    = 1;
   localparam int STAT_FSYNC_BIT  = 2;
   localparam int HANDSHAKE_LIMIT = 20;

   typedef enum logic [1:0] {SEG_SYNC, SEG_BACK, SEG_ACTIVE, SEG_FRONT} lvt_seg_e;

   // first following segment of non-zero length, wrapping round
   function automatic lvt_seg_e lvt_next_seg(input lvt_seg_e cur, input logic [3:0] nz);
      lvt_seg_e   res;
      logic [1:0] probe;
      res = cur;
      for (int k = 3; k >= 1; k--) begin
         probe = 2'(int'(cur) + k);
         if (nz[probe]) res = lvt_seg_e'(probe);
      end
      return res;
   endfunction : lvt_next_seg

endpackage : lvt_pkg

// file: rtl/lvt_sync2.sv
// two-flop synchroniser for levels and toggles
// assumes the input is stable as a level or changes one bit at a time
`timescale 1ns/1ps
module lvt_sync2 import lvt_pkg::*; #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta;

   if (W < 1) begin : g_bad_width
      $error("lvt_sync2: width must be at least 1");
   end

   always_ff @(posedge clk) begin
      meta <= din;
      dout <= meta;
   end
endmodule : lvt_sync2

// file: verification/lvt_panel_model.sv
// panel-side model: measures raster segment lengths seen on the link
// assumes outputs of the timing block change on rising pclk only
`timescale 1ns/1ps
module lvt_panel_model import lvt_pkg::*; (
   input  wire logic             pclk,
   input  wire logic             lineSync,
   input  wire logic             frameSync,
   input  wire logic             dataEnable,
   input  wire logic [PIX_W-1:0] pixelData,
   output logic      [15:0]      syncLen,
   output logic      [15:0]      backLen,
   output logic      [15:0]      actLen,
   output logic      [15:0]      frontLen,
   output logic      [15:0]      fsLines,
   output logic      [15:0]      firstAct,
   output logic      [15:0]      actLines,
   output logic      [15:0]      frameLines,
   output logic      [15:0]      frames,
   output logic      [15:0]      badPix
);
   logic        prevLs, prevFs, prevDe, hadDe, seenAct;
   logic [15:0] run, lineNum, actCnt;

   initial begin
      {prevLs, prevFs, prevDe, hadDe, seenAct} = '0;
      {run, lineNum, actCnt, frames, badPix} = '0;
   end

   always @(posedge pclk) begin
      prevLs <= lineSync;
      prevFs <= frameSync;
      prevDe <= dataEnable;
      // run length of the previous (sync, active) state
      if ({lineSync, dataEnable} != {prevLs, prevDe}) begin
         run <= 16'h0001;
         if (prevLs) syncLen <= run;
         else if (prevDe) actLen <= run;
         else if (dataEnable) backLen <= run;
         else if (hadDe) frontLen <= run;
      end else begin
         run <= run + 16'h0001;
      end
      if (dataEnable && !prevDe) hadDe <= 1'b1;
      if (lineSync && !prevLs) hadDe <= 1'b0;
      if (frameSync && !prevFs) begin
         frames     <= frames + 16'h0001;
         frameLines <= lineNum + 16'h0001;
         actLines   <= actCnt;
         lineNum    <= '0;
         actCnt     <= '0;
         seenAct    <= 1'b0;
      end else begin
         if (lineSync && !prevLs) lineNum <= lineNum + 16'h0001;
         if (prevFs && !frameSync) fsLines <= lineNum + 16'h0001;
         if (dataEnable && !prevDe) begin
            actCnt <= actCnt + 16'h0001;
            if (!seenAct) firstAct <= lineNum;
            seenAct <= 1'b1;
         end
      end
      if (!dataEnable && pixelData !== '0) badPix <= badPix + 16'h0001;
   end
endmodule : lvt_panel_model

// file: verification/test_lvds_video_timing_regs.sv
// self-checking bench for the video timing registers and pattern raster
// assumes the panel model in lvt_panel_model.sv and the lvt_pkg constants
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin totalChecks++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module test_lvds_video_timing_regs import lvt_pkg::*;;
   logic              mclk, rstn, regWr, regRd, pclk;
   logic [REG_AW-1:0] regAddr;
   logic [REG_DW-1:0] regWdata, regRdata;
   logic              lineSync, frameSync, dataEnable, chanAEnable, chanBEnable;
   logic [PIX_W-1:0]  pixelData;
   logic [15:0]       syncLen, backLen, actLen, frontLen, fsLines, firstAct, actLines, frameLines;
   logic [15:0]       frames, badPix;
   int                failures, totalChecks;

   lvt_video_timing_regs uut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pclk(pclk), .lineSync(lineSync),
      .frameSync(frameSync), .dataEnable(dataEnable), .pixelData(pixelData),
      .chanAEnable(chanAEnable), .chanBEnable(chanBEnable));

   lvt_panel_model pm (.pclk(pclk), .lineSync(lineSync), .frameSync(frameSync),
      .dataEnable(dataEnable), .pixelData(pixelData), .syncLen(syncLen), .backLen(backLen),
      .actLen(actLen), .frontLen(frontLen), .fsLines(fsLines), .firstAct(firstAct),
      .actLines(actLines), .frameLines(frameLines), .frames(frames), .badPix(badPix));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // link clock, unrelated phase
   initial begin
      pclk = 1'b0;
      #13;
      forever #40 pclk = ~pclk;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge mclk);
      regWr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge mclk);
      regRd   <= 1'b0;
      #1;
      d = regRdata;
   endtask : rd

   // write then read back the same register with no gap between strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= v;
      regWr    <= 1'b1;
      @(posedge mclk);
      regWr    <= 1'b0;
      regRd    <= 1'b1;
      @(posedge mclk);
      regRd    <= 1'b0;
      #1;
      d = regRdata;
   endtask : wr_rd

   // wait until the pclk side has taken the last write
   task automatic settle;
      logic [7:0] s;
      rd(OFS_STATUS, s);
      for (int n = 0; n < 50 && s[STAT_BUSY_BIT] !== 1'b0; n++) rd(OFS_STATUS, s);
      `CHK("hand-over done", 1'b0, s[STAT_BUSY_BIT])
      repeat (4) @(posedge pclk);
   endtask : settle

   task automatic test_regs;
      logic [7:0] d, v;
      for (int i = 0; i < N_REG; i++) begin
         rd(REG_OFS[i], d);
         `CHK("reset value", REG_RESET, d)
      end
      for (int i = 0; i < N_REG; i++) begin
         v = (i == IDX_PGEN) ? 8'hEF : 8'hFF;
         wr_rd(REG_OFS[i], v, d);
         `CHK("masked readback", v & REG_MASK[i], d)
         wr(REG_OFS[i], 8'h00);
      end
      wr(8'h3B, 8'hFF);
      rd(8'h3B, d);
      `CHK("unmapped read", 8'h00, d)
      `CHK("idle channel A", 1'b0, chanAEnable)
      $display("test regs done");
   endtask : test_regs

   task automatic run_cfg(input logic [9:0] ls, input logic [7:0] lb, input logic [11:0] la,
                          input logic [7:0] lf, input logic [9:0] fs, input logic [7:0] fb,
                          input logic [11:0] fa, input logic [7:0] ff, input logic single);
      logic [15:0] f0;
      logic [7:0]  st;
      wr(OFS_LSYNC_LO, ls[7:0]);
      wr(OFS_LSYNC_HI, {6'h00, ls[9:8]});
      wr(OFS_LINE_BP, lb);
      wr(OFS_ACT_PIX_LO, la[7:0]);
      wr(OFS_ACT_PIX_HI, {4'h0, la[11:8]});
      wr(OFS_LINE_FP, lf);
      wr(OFS_FSYNC_LO, fs[7:0]);
      wr(OFS_FSYNC_HI, {6'h00, fs[9:8]});
      wr(OFS_FRAME_BP, fb);
      wr(OFS_ACT_LINES_LO, fa[7:0]);
      wr(OFS_ACT_LINES_HI, {4'h0, fa[11:8]});
      wr(OFS_FRAME_FP, ff);
      wr(OFS_CHAN_MODE, {3'h0, single, 4'h0});
      settle();
      wr(OFS_PGEN, 8'h10);
      settle();
      f0 = frames;
      for (int n = 0; n < 40000 && frames < f0 + 16'h0003; n++) @(posedge mclk);
      `CHK("frames seen", 1'b1, frames >= f0 + 16'h0003)
      rd(OFS_STATUS, st);
      `CHK("status running", 1'b1, st[STAT_RUN_BIT])
      `CHK("line sync width", 16'(ls), syncLen)
      `CHK("line back porch", 16'(lb), backLen)
      `CHK("active pixels", 16'(la), actLen)
      `CHK("line front porch", 16'(lf), frontLen)
      `CHK("frame sync lines", 16'(fs), fsLines)
      `CHK("first active line", 16'(fs) + 16'(fb), firstAct)
      `CHK("active lines", 16'(fa), actLines)
      `CHK("frame length", 16'(fs) + 16'(fb) + 16'(fa) + 16'(ff), frameLines)
      `CHK("blank pixel data", 16'h0000, badPix)
      `CHK("channel A", 1'b1, chanAEnable)
      `CHK("channel B", ~single, chanBEnable)
      wr(OFS_PGEN, 8'h00);
      settle();
      `CHK("stopped channel A", 1'b0, chanAEnable)
      `CHK("stopped line sync", 1'b0, lineSync)
      `CHK("stopped data enable", 1'b0, dataEnable)
      rd(OFS_STATUS, st);
      `CHK("status stopped", 1'b0, st[STAT_RUN_BIT])
      $display("test pattern config done, single=%0b", single);
   endtask : run_cfg

   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (95000) @(posedge mclk);
      failures++;
      wrap_up();
   end

   initial begin
      failures    = 0;
      totalChecks = 0;
      rstn        = 1'b0;
      regWr       = 1'b0;
      regRd       = 1'b0;
      regAddr     = '0;
      regWdata    = '0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      test_regs();
      // wide line sync uses the upper bits
      run_cfg(10'h102, 8'h03, 12'h004, 8'h02, 10'h002, 8'h01, 12'h003, 8'h02, 1'b1);
      // wide frame sync uses the upper bits, both channels
      run_cfg(10'h001, 8'h02, 12'h002, 8'h01, 10'h101, 8'h03, 12'h002, 8'h04, 1'b0);
      wrap_up();
   end
endmodule : test_lvds_video_timing_regs
